// *** clk_gate_pkg.sv ***
// Shared constants and types for the low-power clock gating link.
// Assumes a single 200 MHz clock shared by the device end and the chipset end.
package clk_gate_pkg;

    localparam int unsigned CLK_MHZ = 200;
    // Stop-grant entry delay after the acknowledge response, in bus clocks.
    localparam int unsigned GRANT_DELAY_CYC = 20;
    localparam logic [4:0] GRANT_DELAY = 5'(GRANT_DELAY_CYC);
    // Longest clock-off interval while throttling, in nanoseconds.
    localparam int unsigned THROTTLE_OFF_MAX_NS = 3000;
    localparam int unsigned THROTTLE_OFF_CYC = (THROTTLE_OFF_MAX_NS * CLK_MHZ) / 1000;
    // Factory duty: clocks off 40 percent of each period.
    localparam int unsigned THROTTLE_PERIOD_CYC = (THROTTLE_OFF_CYC * 100) / 40;
    localparam logic [11:0] THROTTLE_OFF = 12'(THROTTLE_OFF_CYC);
    localparam logic [11:0] THROTTLE_PERIOD = 12'(THROTTLE_PERIOD_CYC);
    localparam logic [11:0] HYST_CYCLES = 12'h3e8;
    localparam logic [1:0] RESET_MIN_CYC = 2'h3;
    // Reset pulse the chipset drives, in clocks after the first low cycle.
    localparam logic [3:0] RESET_HOLD = 4'h8;
    localparam logic [3:0] RATIO_RESET = 4'h8;
    localparam logic [3:0] SLEEP_EXIT_GAP = 4'h2;

    typedef enum logic [4:0] {
        ST_NORMAL = 5'h01,
        ST_HALT = 5'h02,
        ST_GRANT = 5'h04,
        ST_SNOOP = 5'h08,
        ST_SLEEP = 5'h10
    } power_state_type;

endpackage : clk_gate_pkg

// *** power_link_if.sv ***
// Chipset-to-device low-power link: sleep, stop-clock, reset, snoop and interrupt.
// Assumes both ends run on the same clock; active-low pins carry _n.
`timescale 1ns/1ps
`default_nettype none
interface power_link_if;
    logic sleep_request_n;
    logic stop_clock_request_n;
    logic reset_n;
    logic snoop_req;
    logic snoop_done;
    logic irq;
    logic grant_ack;
    logic [3:0] ratio_cfg;

    modport device (
        input sleep_request_n, stop_clock_request_n, reset_n, snoop_req, irq, ratio_cfg,
        output snoop_done, grant_ack
    );
    modport chipset (
        output sleep_request_n, stop_clock_request_n, reset_n, snoop_req, irq, ratio_cfg,
        input snoop_done, grant_ack
    );
endinterface : power_link_if
`default_nettype wire

// *** thermal_clock_throttle.sv ***
// Thermal clock modulation with fixed duty and hysteresis.
// Assumes over_temp comes from an on-die sensor on the same clock.
`timescale 1ns/1ps
`default_nettype none
module thermal_clock_throttle
    import clk_gate_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic over_temp,
    output logic throttle_active,
    output logic clock_off
);
    typedef struct packed {
        logic active;
        logic off;
        logic [11:0] phase;
        logic [11:0] hyst;
    } state_type;

    state_type s_q, s_d;

    // The trip point is the sensor's own; nothing here lets software move it.
    always_comb begin
        s_d = s_q;
        if (over_temp) begin
            s_d.active = 1'b1;
            s_d.hyst = HYST_CYCLES;
        end else if (s_q.active) begin
            if (s_q.hyst == 12'h000) begin
                s_d.active = 1'b0;
            end else begin
                s_d.hyst = s_q.hyst - 12'h001;
            end
        end
        if (s_d.active) begin
            // Off for the first part of each period; duty is a constant.
            s_d.phase = (s_q.phase >= THROTTLE_PERIOD - 12'h001) ? 12'h000
                : s_q.phase + 12'h001;
            s_d.off = s_d.phase < THROTTLE_OFF;
        end else begin
            s_d.phase = 12'h000;
            s_d.off = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign throttle_active = s_q.active;
    assign clock_off = s_q.off;
endmodule : thermal_clock_throttle
`default_nettype wire

// *** power_state_device.sv ***
// Device end: power state machine, clock gating, snoop and interrupt handling.
// Assumes the chipset drives the link pins on the same clock; all but ratio_cfg still pass two-stage synchronisers.
`timescale 1ns/1ps
`default_nettype none
module power_state_device
    import clk_gate_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    power_link_if.device link,
    input wire logic halt_exec,
    input wire logic wake_event,
    input wire logic over_temp,
    input wire logic msr_ratio_we,
    input wire logic [3:0] msr_ratio_data,
    output logic core_clk_en,
    output logic pll_run,
    output logic context_hold,
    output logic irq_pending,
    input wire logic irq_taken,
    output logic [3:0] bus_ratio,
    output power_state_type power_state,
    output logic throttle_active
);
    typedef struct packed {
        power_state_type st;
        power_state_type snoop_ret;
        logic [1:0] slp_sync;
        logic [1:0] stp_sync;
        logic [1:0] rst_sync;
        logic [1:0] snp_sync;
        logic [1:0] irq_sync;
        logic [4:0] grant_cnt;
        logic ack_q;
        logic [1:0] rst_cnt;
        logic warm_done;
        logic irq_pend;
        logic snoop_done;
        logic [3:0] ratio_pend;
        logic [3:0] ratio;
    } state_type;

    state_type s_q, s_d;
    logic clock_off;
    logic slp, stp, rst_pin, snp, irq_in;

    thermal_clock_throttle u_throttle (
        .clk(clk),
        .rst(rst),
        .over_temp(over_temp),
        .throttle_active(throttle_active),
        .clock_off(clock_off)
    );

    assign slp = ~s_q.slp_sync[1];
    assign stp = ~s_q.stp_sync[1];
    assign rst_pin = ~s_q.rst_sync[1];
    assign snp = s_q.snp_sync[1];
    assign irq_in = s_q.irq_sync[1];

    always_comb begin
        s_d = s_q;
        s_d.slp_sync = {s_q.slp_sync[0], link.sleep_request_n};
        s_d.stp_sync = {s_q.stp_sync[0], link.stop_clock_request_n};
        s_d.rst_sync = {s_q.rst_sync[0], link.reset_n};
        s_d.snp_sync = {s_q.snp_sync[0], link.snoop_req};
        s_d.irq_sync = {s_q.irq_sync[0], link.irq};
        s_d.snoop_done = 1'b0;
        s_d.warm_done = 1'b0;
        if (irq_taken) begin
            s_d.irq_pend = 1'b0;
        end
        // Latched in every state but sleep, throttled or not; set wins over take.
        if (irq_in && s_q.st != ST_SLEEP) begin
            s_d.irq_pend = 1'b1;
        end
        // Straps are staged while reset is held and an MSR write stages one too;
        // the live ratio itself only moves at the end of a warm reset.
        if (rst_pin) begin
            s_d.ratio_pend = link.ratio_cfg;
        end
        if (msr_ratio_we) begin
            s_d.ratio_pend = msr_ratio_data;
        end
        if (rst_pin) begin
            if (s_q.rst_cnt != RESET_MIN_CYC) begin
                s_d.rst_cnt = s_q.rst_cnt + 2'h1;
            end
        end else begin
            s_d.rst_cnt = 2'h0;
            // Ratio only takes effect at the end of a warm reset.
            if (s_q.rst_cnt == RESET_MIN_CYC) begin
                s_d.ratio = s_q.ratio_pend;
                s_d.warm_done = 1'b1;
            end
        end
        case (s_q.st)
            ST_NORMAL: begin
                s_d.ack_q = 1'b0;
                if (stp) begin
                    s_d.grant_cnt = s_q.grant_cnt + 5'h01;
                    if (s_q.grant_cnt == GRANT_DELAY) begin
                        s_d.st = ST_GRANT;
                        s_d.grant_cnt = 5'h00;
                    end
                    s_d.ack_q = 1'b1;
                end else if (halt_exec) begin
                    s_d.st = ST_HALT;
                    s_d.grant_cnt = 5'h00;
                end else begin
                    s_d.grant_cnt = 5'h00;
                end
            end
            ST_HALT: begin
                // Sleep requests are not looked at here.
                if (snp) begin
                    s_d.st = ST_SNOOP;
                    s_d.snoop_ret = ST_HALT;
                    s_d.snoop_done = 1'b1;
                end else if (wake_event || irq_in) begin
                    s_d.st = ST_NORMAL;
                end else if (stp) begin
                    s_d.st = ST_NORMAL;
                end
            end
            ST_GRANT: begin
                s_d.ack_q = 1'b0;
                if (slp) begin
                    s_d.st = ST_SLEEP;
                end else if (snp) begin
                    s_d.st = ST_SNOOP;
                    s_d.snoop_ret = ST_GRANT;
                    s_d.snoop_done = 1'b1;
                end else if (!stp) begin
                    s_d.st = ST_NORMAL;
                end
            end
            ST_SNOOP: begin
                // The answer left on entry, since the chipset holds the request until it
                // sees it; waiting for the request to fall keeps one snoop from counting twice.
                if (!snp) begin
                    s_d.st = s_q.snoop_ret;
                end
            end
            ST_SLEEP: begin
                // Only the sleep pin and reset are watched; snoops are dropped.
                // The chipset drops sleep together with reset, so reset must hold the state here.
                if (!slp && !rst_pin) begin
                    s_d.st = ST_GRANT;
                end
            end
            default: begin
                s_d.st = ST_NORMAL;
            end
        endcase
        // A reset held long enough leaves sleep directly, skipping stop-grant.
        if (s_q.rst_cnt == RESET_MIN_CYC) begin
            s_d.st = ST_NORMAL;
            s_d.grant_cnt = 5'h00;
            s_d.ack_q = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_q <= '{st: ST_NORMAL, snoop_ret: ST_GRANT, slp_sync: 2'h3, stp_sync: 2'h3,
                     rst_sync: 2'h3, snp_sync: 2'h0, irq_sync: 2'h0, grant_cnt: 5'h00,
                     ack_q: 1'b0, rst_cnt: 2'h0, warm_done: 1'b0, irq_pend: 1'b0,
                     snoop_done: 1'b0, ratio_pend: RATIO_RESET, ratio: RATIO_RESET};
        end else begin
            s_q <= s_d;
        end
    end

    // Gating follows the state; the PLL never drops and context is held in every state but normal.
    assign core_clk_en = (s_q.st == ST_NORMAL) && !clock_off;
    assign pll_run = 1'b1;
    assign context_hold = (s_q.st != ST_NORMAL);
    assign irq_pending = s_q.irq_pend;
    assign bus_ratio = s_q.ratio;
    assign power_state = s_q.st;
    assign link.snoop_done = s_q.snoop_done;
    assign link.grant_ack = s_q.ack_q;
endmodule : power_state_device
`default_nettype wire

// *** power_chipset.sv ***
// Chipset end: sequences stop-clock, sleep and reset toward the device.
// Assumes user commands are single-cycle pulses on the same clock.
`timescale 1ns/1ps
`default_nettype none
module power_chipset
    import clk_gate_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    power_link_if.chipset link,
    input wire logic go_sleep,
    input wire logic go_wake,
    input wire logic do_reset,
    input wire logic snoop_start,
    input wire logic irq_in,
    input wire logic [3:0] ratio_in,
    input wire logic device_in_grant,
    output logic sleeping,
    output logic busy
);
    typedef enum logic [4:0] {
        CS_IDLE = 5'h01,
        CS_STOP = 5'h02,
        CS_SLEEP = 5'h04,
        CS_EXIT = 5'h08,
        CS_RESET = 5'h10
    } cs_state_type;

    typedef struct packed {
        cs_state_type st;
        logic slp_n;
        logic stp_n;
        logic rst_n;
        logic snp;
        logic irq;
        logic [3:0] ratio;
        logic [3:0] cnt;
    } state_type;

    state_type s_q, s_d;

    always_comb begin
        s_d = s_q;
        s_d.cnt = (s_q.cnt != 4'h0) ? s_q.cnt - 4'h1 : 4'h0;
        // Snoops only in idle or stop-clock, interrupts only in idle.
        s_d.snp = snoop_start && (s_q.st == CS_IDLE || s_q.st == CS_STOP) ? 1'b1
            : (link.snoop_done ? 1'b0 : s_q.snp);
        s_d.irq = irq_in && (s_q.st == CS_IDLE);
        case (s_q.st)
            CS_IDLE: begin
                if (do_reset) begin
                    s_d.st = CS_RESET;
                    s_d.rst_n = 1'b0;
                    s_d.ratio = ratio_in;
                    s_d.cnt = RESET_HOLD;
                end else if (go_sleep) begin
                    s_d.st = CS_STOP;
                    s_d.stp_n = 1'b0;
                end
            end
            CS_STOP: begin
                // Sleep asserted only once the device reports stop-grant.
                if (device_in_grant && !s_q.snp) begin
                    s_d.slp_n = 1'b0;
                    s_d.st = CS_SLEEP;
                end
            end
            CS_SLEEP: begin
                if (do_reset) begin
                    // Drop both requests in the same cycle that reset asserts.
                    s_d.rst_n = 1'b0;
                    s_d.slp_n = 1'b1;
                    s_d.stp_n = 1'b1;
                    s_d.ratio = ratio_in;
                    s_d.cnt = RESET_HOLD;
                    s_d.st = CS_RESET;
                end else if (go_wake) begin
                    s_d.slp_n = 1'b1;
                    s_d.cnt = SLEEP_EXIT_GAP;
                    s_d.st = CS_EXIT;
                end
            end
            CS_EXIT: begin
                if (s_q.cnt == 4'h0) begin
                    s_d.stp_n = 1'b1;
                    s_d.st = CS_IDLE;
                end
            end
            CS_RESET: begin
                if (s_q.cnt == 4'h0) begin
                    s_d.rst_n = 1'b1;
                    s_d.st = CS_IDLE;
                end
            end
            default: begin
                s_d.st = CS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_q <= '{st: CS_IDLE, slp_n: 1'b1, stp_n: 1'b1, rst_n: 1'b1, snp: 1'b0,
                     irq: 1'b0, ratio: RATIO_RESET, cnt: 4'h0};
        end else begin
            s_q <= s_d;
        end
    end

    assign link.sleep_request_n = s_q.slp_n;
    assign link.stop_clock_request_n = s_q.stp_n;
    assign link.reset_n = s_q.rst_n;
    assign link.snoop_req = s_q.snp;
    assign link.irq = s_q.irq;
    // The ratio only moves while reset is driven.
    assign link.ratio_cfg = s_q.ratio;
    assign sleeping = (s_q.st == CS_SLEEP);
    assign busy = (s_q.st != CS_IDLE);
endmodule : power_chipset
`default_nettype wire

// *** sleep_and_thermal_clock_gating_properties.sv ***
// Checker for the low-power link between the chipset end and the device end.
// Assumes it sits beside the link interface and sees only its signals.
`timescale 1ns/1ps
`default_nettype none
module sleep_and_thermal_clock_gating_properties (
    input wire logic clk,
    input wire logic rst,
    input wire logic sleep_request_n,
    input wire logic stop_clock_request_n,
    input wire logic reset_n,
    input wire logic snoop_req,
    input wire logic snoop_done,
    input wire logic irq,
    input wire logic grant_ack,
    input wire logic [3:0] ratio_cfg
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    sequence stop_seen_s;
        $fell(stop_clock_request_n) && sleep_request_n && reset_n;
    endsequence
    sequence reset_in_sleep_s;
        !$past(sleep_request_n) && $fell(reset_n);
    endsequence
    sequence deep_sleep_s;
        !sleep_request_n [*4];
    endsequence

    stop_before_sleep_a: assert property (!sleep_request_n |-> !stop_clock_request_n)
        else $error("sleep request without stop-clock request");
    wake_gap_a: assert property ($rose(stop_clock_request_n) && reset_n |-> $past(sleep_request_n))
        else $error("stop-clock released before sleep request");
    // Reset is exempt because the chipset must drop both pins at once then.
    quiet_in_sleep_a: assert property (!sleep_request_n && !$past(sleep_request_n) && reset_n
        |-> $stable(stop_clock_request_n) && $stable(snoop_req) && $stable(irq) && $stable(ratio_cfg))
        else $error("link pin moved while device asleep");
    no_sleep_snoop_a: assert property (!sleep_request_n |-> !snoop_req)
        else $error("snoop issued during sleep");
    reset_release_a: assert property (reset_in_sleep_s |-> ##[0:2] (sleep_request_n && stop_clock_request_n))
        else $error("sleep or stop-clock held after reset in sleep");
    reset_hold_a: assert property ($fell(reset_n) |-> !reset_n [*3])
        else $error("reset pulse too short");
    grant_ack_a: assert property (stop_seen_s |-> ##[1:5] grant_ack)
        else $error("no stop-grant acknowledge");
    grant_hold_a: assert property ($rose(grant_ack) && !stop_clock_request_n |-> grant_ack [*8])
        else $error("acknowledge dropped early");
    snoop_serve_a: assert property ($rose(snoop_req) && sleep_request_n |-> ##[1:12] snoop_done)
        else $error("snoop not serviced");
    asleep_silent_a: assert property (deep_sleep_s |-> !snoop_done)
        else $error("snoop answered while asleep");
endmodule : sleep_and_thermal_clock_gating_properties
`default_nettype wire

// *** sleep_and_thermal_clock_gating_tb.sv ***
// Testbench joining the device end and the chipset end through the link interface.
// Assumes the package constants; inputs change 1 ns after each rising edge.
`timescale 1ns/1ps
`default_nettype none
module sleep_and_thermal_clock_gating_tb import clk_gate_pkg::*;;
    logic clk, rst, halt_exec, wake_event, over_temp, msr_ratio_we, irq_taken, allow_grant;
    logic go_sleep, go_wake, do_reset, snoop_start, irq_in, device_in_grant, seen_grant;
    logic core_clk_en, pll_run, context_hold, irq_pending, throttle_active, sleeping, busy;
    logic [3:0] msr_ratio_data, ratio_in, bus_ratio;
    logic [15:0] lfsr_q;
    power_state_type power_state;
    int fails, cmp_count, cyc, n, off_cnt, run, max_run;
    // Model of the staged ratio: every staging in order; the last one wins at warm reset.
    int ratio_q[$];
    int model_ratio;

    power_link_if power_link_if_inst ();
    power_state_device power_state_device_inst (.clk(clk), .rst(rst), .link(power_link_if_inst),
        .halt_exec(halt_exec), .wake_event(wake_event), .over_temp(over_temp),
        .msr_ratio_we(msr_ratio_we), .msr_ratio_data(msr_ratio_data), .core_clk_en(core_clk_en),
        .pll_run(pll_run), .context_hold(context_hold), .irq_pending(irq_pending),
        .irq_taken(irq_taken), .bus_ratio(bus_ratio), .power_state(power_state),
        .throttle_active(throttle_active));
    power_chipset power_chipset_inst (.clk(clk), .rst(rst), .link(power_link_if_inst),
        .go_sleep(go_sleep), .go_wake(go_wake), .do_reset(do_reset), .snoop_start(snoop_start),
        .irq_in(irq_in), .ratio_in(ratio_in), .device_in_grant(device_in_grant),
        .sleeping(sleeping), .busy(busy));
    sleep_and_thermal_clock_gating_properties sleep_and_thermal_clock_gating_properties_inst (
        .clk(clk), .rst(rst), .sleep_request_n(power_link_if_inst.sleep_request_n),
        .stop_clock_request_n(power_link_if_inst.stop_clock_request_n),
        .reset_n(power_link_if_inst.reset_n), .snoop_req(power_link_if_inst.snoop_req),
        .snoop_done(power_link_if_inst.snoop_done), .irq(power_link_if_inst.irq),
        .grant_ack(power_link_if_inst.grant_ack), .ratio_cfg(power_link_if_inst.ratio_cfg));

    // Holding this low parks the device in stop-grant so a snoop can be aimed there.
    assign device_in_grant = allow_grant && (power_state == ST_GRANT || power_state == ST_SLEEP);

    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr_next

    task automatic finish_test;
        if (fails == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : finish_test

    task automatic check(input logic [11:0] got, input logic [11:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : check

    task automatic step(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask : step

    task automatic wait_state(input power_state_type s, input int lim);
        n = 0;
        while (power_state !== s && n < lim) begin
            step(1);
            n++;
        end
        check(12'(power_state), 12'(s));
    endtask : wait_state

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            finish_test();
        end
    end

    initial begin
        {rst, halt_exec, wake_event, over_temp, msr_ratio_we, irq_taken} = 6'h20;
        {go_sleep, go_wake, do_reset, snoop_start, irq_in, allow_grant} = 6'h01;
        msr_ratio_data = 4'h0;
        ratio_in = RATIO_RESET;
        model_ratio = int'(RATIO_RESET);
        lfsr_q = 16'he3ff;
        step(12);
        rst = 1'b0;
        step(1);
        check(12'(power_state), 12'(ST_NORMAL));
        check(12'({bus_ratio, core_clk_en, pll_run}), 12'({RATIO_RESET, 2'h3}));
        for (int i = 0; i < 3; i++) begin
            lfsr_q = lfsr_next(lfsr_q);
            msr_ratio_data = lfsr_q[3:0];
            ratio_q.push_back(int'(lfsr_q[3:0]));
            msr_ratio_we = 1'b1;
            step(1);
            msr_ratio_we = 1'b0;
            step(4);
            check(12'(bus_ratio), 12'(model_ratio));
        end
        ratio_in = msr_ratio_data;
        halt_exec = 1'b1;
        wait_state(ST_HALT, 10);
        check(12'(core_clk_en), 12'h000);
        snoop_start = 1'b1;
        step(1);
        snoop_start = 1'b0;
        wait_state(ST_SNOOP, 12);
        wait_state(ST_HALT, 20);
        halt_exec = 1'b0;
        wake_event = 1'b1;
        step(1);
        wake_event = 1'b0;
        wait_state(ST_NORMAL, 10);
        allow_grant = 1'b0;
        go_sleep = 1'b1;
        step(1);
        go_sleep = 1'b0;
        n = 0;
        while (power_link_if_inst.grant_ack !== 1'b1 && n < 10) begin
            step(1);
            n++;
        end
        wait_state(ST_GRANT, 40);
        check(12'(n), 12'(GRANT_DELAY_CYC));
        snoop_start = 1'b1;
        step(1);
        snoop_start = 1'b0;
        wait_state(ST_SNOOP, 12);
        wait_state(ST_GRANT, 20);
        allow_grant = 1'b1;
        wait_state(ST_SLEEP, 20);
        check(12'({core_clk_en, pll_run, context_hold, sleeping}), 12'h007);
        irq_in = 1'b1;
        step(1);
        irq_in = 1'b0;
        step(10);
        check(12'(irq_pending), 12'h000);
        go_wake = 1'b1;
        step(1);
        go_wake = 1'b0;
        wait_state(ST_NORMAL, 60);
        over_temp = 1'b1;
        step(1);
        check(12'(throttle_active), 12'h001);
        irq_in = 1'b1;
        step(1);
        irq_in = 1'b0;
        {off_cnt, run, max_run} = '0;
        // Two whole periods give an exact off count whatever the starting phase.
        repeat (2 * THROTTLE_PERIOD_CYC) begin
            run = (core_clk_en === 1'b0) ? run + 1 : 0;
            off_cnt += (core_clk_en === 1'b0);
            max_run = (run > max_run) ? run : max_run;
            step(1);
        end
        check(12'(off_cnt), 12'(2 * THROTTLE_OFF_CYC));
        check(12'(max_run), THROTTLE_OFF);
        check(12'(irq_pending), 12'h001);
        irq_taken = 1'b1;
        step(1);
        irq_taken = 1'b0;
        step(2);
        check(12'(irq_pending), 12'h000);
        over_temp = 1'b0;
        step(int'(HYST_CYCLES) - 10);
        check(12'(throttle_active), 12'h001);
        n = 0;
        while (throttle_active !== 1'b0 && n < 30) begin
            step(1);
            n++;
        end
        step(2);
        check(12'({throttle_active, core_clk_en}), 12'h001);
        go_sleep = 1'b1;
        step(1);
        go_sleep = 1'b0;
        wait_state(ST_SLEEP, 60);
        do_reset = 1'b1;
        ratio_q.push_back(int'(ratio_in));
        model_ratio = ratio_q[$];
        step(1);
        do_reset = 1'b0;
        seen_grant = 1'b0;
        n = 0;
        while ((busy !== 1'b0 || power_state !== ST_NORMAL) && n < 80) begin
            seen_grant |= (power_state === ST_GRANT);
            step(1);
            n++;
        end
        check(12'(seen_grant), 12'h000);
        step(4);
        check(12'(power_state), 12'(ST_NORMAL));
        check(12'(bus_ratio), 12'(model_ratio));
        check(12'({power_link_if_inst.sleep_request_n, power_link_if_inst.stop_clock_request_n}),
            12'h003);
        finish_test();
    end
endmodule : sleep_and_thermal_clock_gating_tb
`default_nettype wire
